// file: drp_consts.svh
// Offsets, field positions, reset values and timing counts of the drive port block.
// Functional notes
// - A remote reset line assertion raises a reset indication, like reset received.
// - Serial port takes incoming serial data from the host-to-drive path.
// - Serial port sends its serial data on the drive-to-host path.
// - Dual indicators: link on with carrier; no carrier clears link and activity.
// - Dual indicators: activity blinks during traffic on either pair, else off.
// - Link only: off without carrier, steady with carrier, blinking on receive traffic.
// - Network port supports autonegotiation of link speed.
// - Network port drives pair one as MDI, pair two in crossover configuration.
// - Serial bytes are asynchronous NRZ: one start, no parity, one stop bit.
// - Serial paths run at 9600 baud by default; other rates are allowed.
`ifndef DRP_CONSTS_SVH
`define DRP_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DRP_OFF_CTRL 5'h00
`define DRP_OFF_STATUS 5'h04
`define DRP_OFF_IRQ_STATUS 5'h08
`define DRP_OFF_IRQ_MASK 5'h0C
`define DRP_OFF_BAUD_DIV 5'h10
`define DRP_OFF_TX_DATA 5'h14
`define DRP_OFF_RX_DATA 5'h18

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define DRP_CTRL_DUAL 0
`define DRP_CTRL_XOVER 1
`define DRP_CTRL_ANEG 2
`define DRP_CTRL_IND_EN 3
`define DRP_CTRL_ANEG_RESTART 4
`define DRP_CTRL_RST 4'hD
`define DRP_IRQ_RESET 0
`define DRP_IRQ_CARRIER 1
`define DRP_IRQ_RX 2
`define DRP_IRQ_TX 3
`define DRP_IRQ_FRAME 4
`define DRP_IRQ_W 5

// ----------------------------------------
// Timing
// ----------------------------------------
`define DRP_CLK_HZ 100000000
`define DRP_BAUD 9600
`define DRP_BAUD_DIV_RST 16'((`DRP_CLK_HZ) / (`DRP_BAUD))
`define DRP_BLINK_HALF_MS 100
`define DRP_BLINK_CYCLES ((`DRP_BLINK_HALF_MS) * ((`DRP_CLK_HZ) / 1000))

`endif

// file: drp_pkg.sv
// Types shared by the drive port block.
package drp_pkg;

  typedef struct packed {
    logic remote_reset;
    logic carrier;
    logic tx_traffic;
    logic rx_traffic;
    logic serial_rx;
  } drp_pins_t;

  typedef struct packed {
    logic aneg_restart;
    logic ind_en;
    logic aneg;
    logic xover;
    logic dual;
  } drp_ctrl_t;

  typedef enum logic [3:0] {
    SER_IDLE = 4'h1,
    SER_START = 4'h2,
    SER_DATA = 4'h4,
    SER_STOP = 4'h8
  } drp_ser_state_t;

endpackage

// file: drp_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/100ps
module drp_sync
  import drp_pkg::*;
#(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [WIDTH-1:0] D,
  output logic [WIDTH-1:0] Q
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  // The first stage feeds only the second; a change counts once stages two and three agree.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      s1 <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
      Q <= RESET_VAL;
    end
    else
    begin
      s1 <= D;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < WIDTH; i++)
      begin
        if (s2[i] == s3[i])
        begin
          Q[i] <= s3[i];
        end
      end
    end
  end

endmodule

// file: drp_top.sv
// Drive port link status, serial paths, remote reset and indicator logic.
`timescale 1ns/100ps
`include "drp_consts.svh"
module drp_top
  import drp_pkg::*;
#(
  parameter int BLINK_CYCLES = `DRP_BLINK_CYCLES
)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic IRQ,
  input wire logic REMOTE_RESET,
  input wire logic CARRIER_DETECT,
  input wire logic TX_TRAFFIC,
  input wire logic RX_TRAFFIC,
  input wire logic [1:0] LINK_SPEED,
  input wire logic SERIAL_RX,
  output logic SERIAL_TX,
  output logic RESET_IND,
  output logic LINK_INDICATOR,
  output logic ACTIVITY_INDICATOR,
  output logic PAIR_ONE_EN,
  output logic PAIR_TWO_EN,
  output logic AUTONEG_EN,
  output logic AUTONEG_RESTART
);

  localparam int BW = (BLINK_CYCLES > 1) ? $clog2(BLINK_CYCLES) : 1;

  drp_pins_t pins_raw;
  drp_pins_t pins_s;
  drp_ctrl_t ctrl;
  drp_ser_state_t tx_state;
  drp_ser_state_t rx_state;
  logic [`DRP_IRQ_W-1:0] irq_status;
  logic [`DRP_IRQ_W-1:0] irq_mask;
  logic [`DRP_IRQ_W-1:0] events;
  logic [`DRP_IRQ_W-1:0] rd_irq;
  logic [15:0] baud_div;
  logic ack;
  logic req;
  logic wr_go;
  logic rd_go;
  logic [31:0] next_readdata;
  logic rr_prev;
  logic carrier_prev;
  logic [BW-1:0] blink_cnt;
  logic blink_phase;
  logic next_link;
  logic next_act;
  logic [15:0] tx_cnt;
  logic [2:0] tx_bit;
  logic [7:0] tx_shift;
  logic tx_go;
  logic ev_tx;
  logic [15:0] rx_cnt;
  logic [2:0] rx_bit;
  logic [7:0] rx_shift;
  logic [7:0] rx_data;
  logic rx_full;
  logic ev_rx;
  logic ev_frame;

  function automatic logic [31:0] be_merge(logic [31:0] old, logic [31:0] wd, logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  assign pins_raw = '{REMOTE_RESET, CARRIER_DETECT, TX_TRAFFIC, RX_TRAFFIC, SERIAL_RX};

  // The serial line idles high, so its stages reset high to avoid a false start bit.
  drp_sync #(.WIDTH(5), .RESET_VAL(5'h01)) u_sync (
    .CLK(CLK),
    .RST_N(RST_N),
    .D(pins_raw),
    .Q(pins_s)
  );

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  // One wait state: data is captured on the first edge and handed over on the second.
  assign req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack;
  assign wr_go = AVS_WRITE & ack;
  assign rd_go = AVS_READ & ack;

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      ack <= 1'b0;
    end
    else
    begin
      ack <= req & ~ack;
    end
  end

  always_comb
  begin
    next_readdata = 32'h0;
    unique case (AVS_ADDRESS)
      `DRP_OFF_CTRL: next_readdata[4:0] = ctrl;
      `DRP_OFF_STATUS: next_readdata[6:0] = {LINK_SPEED, pins_s.remote_reset, rx_full,
        ~tx_state[0], pins_s.tx_traffic | pins_s.rx_traffic, pins_s.carrier};
      `DRP_OFF_IRQ_STATUS: next_readdata[`DRP_IRQ_W-1:0] = irq_status;
      `DRP_OFF_IRQ_MASK: next_readdata[`DRP_IRQ_W-1:0] = irq_mask;
      `DRP_OFF_BAUD_DIV: next_readdata[15:0] = baud_div;
      `DRP_OFF_RX_DATA: next_readdata[7:0] = rx_data;
      default: next_readdata = 32'h0;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      AVS_READDATA <= 32'h0;
    end
    else if (AVS_READ && !ack)
    begin
      AVS_READDATA <= next_readdata;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      ctrl <= 5'(`DRP_CTRL_RST);
      irq_mask <= '0;
      baud_div <= `DRP_BAUD_DIV_RST;
    end
    else
    begin
      ctrl.aneg_restart <= 1'b0;
      if (wr_go && AVS_ADDRESS == `DRP_OFF_CTRL)
      begin
        ctrl <= 5'(be_merge(32'(ctrl) & 32'hF, AVS_WRITEDATA, AVS_BYTEENABLE));
      end
      if (wr_go && AVS_ADDRESS == `DRP_OFF_IRQ_MASK)
      begin
        irq_mask <= `DRP_IRQ_W'(be_merge(32'(irq_mask), AVS_WRITEDATA, AVS_BYTEENABLE));
      end
      if (wr_go && AVS_ADDRESS == `DRP_OFF_BAUD_DIV)
      begin
        baud_div <= 16'(be_merge(32'(baud_div), AVS_WRITEDATA, AVS_BYTEENABLE));
      end
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  // Only the bits returned by the read are cleared, and a new event wins over the clear.
  assign events = {ev_frame, ev_tx, ev_rx, pins_s.carrier ^ carrier_prev, RESET_IND};
  assign rd_irq = (rd_go && AVS_ADDRESS == `DRP_OFF_IRQ_STATUS) ?
    AVS_READDATA[`DRP_IRQ_W-1:0] : '0;

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      irq_status <= '0;
      IRQ <= 1'b0;
    end
    else
    begin
      irq_status <= (irq_status & ~rd_irq) | events;
      IRQ <= |(((irq_status & ~rd_irq) | events) & irq_mask);
    end
  end

  // ----------------------------------------
  // Remote reset and network port pins
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      rr_prev <= 1'b0;
      carrier_prev <= 1'b0;
      RESET_IND <= 1'b0;
    end
    else
    begin
      rr_prev <= pins_s.remote_reset;
      carrier_prev <= pins_s.carrier;
      RESET_IND <= pins_s.remote_reset & ~rr_prev;
    end
  end

  assign PAIR_ONE_EN = ~ctrl.xover;
  assign PAIR_TWO_EN = ctrl.xover;
  assign AUTONEG_EN = ctrl.aneg;
  assign AUTONEG_RESTART = ctrl.aneg_restart;

  // ----------------------------------------
  // Indicators
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      blink_cnt <= '0;
      blink_phase <= 1'b0;
    end
    else if (blink_cnt == BW'(BLINK_CYCLES - 1))
    begin
      blink_cnt <= '0;
      blink_phase <= ~blink_phase;
    end
    else
    begin
      blink_cnt <= blink_cnt + BW'(1);
    end
  end

  always_comb
  begin
    next_link = 1'b0;
    next_act = 1'b0;
    if (ctrl.ind_en && pins_s.carrier)
    begin
      if (ctrl.dual)
      begin
        next_link = 1'b1;
        next_act = (pins_s.tx_traffic | pins_s.rx_traffic) & blink_phase;
      end
      else
      begin
        next_link = pins_s.rx_traffic ? blink_phase : 1'b1;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      LINK_INDICATOR <= 1'b0;
      ACTIVITY_INDICATOR <= 1'b0;
    end
    else
    begin
      LINK_INDICATOR <= next_link;
      ACTIVITY_INDICATOR <= next_act;
    end
  end

  // ----------------------------------------
  // Serial transmitter, drive-to-host path
  // ----------------------------------------
  // A byte written while busy is dropped; software polls the busy bit or the done event.
  assign tx_go = wr_go && AVS_ADDRESS == `DRP_OFF_TX_DATA && AVS_BYTEENABLE[0];

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      tx_state <= SER_IDLE;
      SERIAL_TX <= 1'b1;
      tx_cnt <= 16'h0;
      tx_bit <= 3'h0;
      tx_shift <= 8'h00;
      ev_tx <= 1'b0;
    end
    else
    begin
      ev_tx <= 1'b0;
      tx_cnt <= (tx_state == SER_IDLE || tx_cnt == baud_div - 16'h1) ? 16'h0 : tx_cnt + 16'h1;
      unique case (tx_state)
        SER_IDLE:
          if (tx_go)
          begin
            tx_shift <= AVS_WRITEDATA[7:0];
            SERIAL_TX <= 1'b0;
            tx_state <= SER_START;
          end
        SER_START:
          if (tx_cnt == baud_div - 16'h1)
          begin
            SERIAL_TX <= tx_shift[0];
            tx_bit <= 3'h0;
            tx_state <= SER_DATA;
          end
        SER_DATA:
          if (tx_cnt == baud_div - 16'h1)
          begin
            if (tx_bit == 3'h7)
            begin
              SERIAL_TX <= 1'b1;
              tx_state <= SER_STOP;
            end
            else
            begin
              SERIAL_TX <= tx_shift[1];
              tx_shift <= {1'b0, tx_shift[7:1]};
              tx_bit <= tx_bit + 3'h1;
            end
          end
        SER_STOP:
          if (tx_cnt == baud_div - 16'h1)
          begin
            ev_tx <= 1'b1;
            tx_state <= SER_IDLE;
          end
      endcase
    end
  end

  // ----------------------------------------
  // Serial receiver, host-to-drive path
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      rx_state <= SER_IDLE;
      rx_cnt <= 16'h0;
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
      rx_data <= 8'h00;
      rx_full <= 1'b0;
      ev_rx <= 1'b0;
      ev_frame <= 1'b0;
    end
    else
    begin
      ev_rx <= 1'b0;
      ev_frame <= 1'b0;
      if (rd_go && AVS_ADDRESS == `DRP_OFF_RX_DATA)
      begin
        rx_full <= 1'b0;
      end
      rx_cnt <= rx_cnt + 16'h1;
      unique case (rx_state)
        SER_IDLE:
        begin
          rx_cnt <= 16'h0;
          if (!pins_s.serial_rx)
          begin
            rx_state <= SER_START;
          end
        end
        SER_START:
          if (rx_cnt == {1'b0, baud_div[15:1]})
          begin
            rx_cnt <= 16'h0;
            rx_bit <= 3'h0;
            rx_state <= pins_s.serial_rx ? SER_IDLE : SER_DATA;
          end
        SER_DATA:
          if (rx_cnt == baud_div - 16'h1)
          begin
            rx_cnt <= 16'h0;
            rx_shift <= {pins_s.serial_rx, rx_shift[7:1]};
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == 3'h7)
            begin
              rx_state <= SER_STOP;
            end
          end
        SER_STOP:
          if (rx_cnt == baud_div - 16'h1)
          begin
            rx_state <= SER_IDLE;
            if (pins_s.serial_rx)
            begin
              rx_data <= rx_shift;
              rx_full <= 1'b1;
              ev_rx <= 1'b1;
            end
            else
            begin
              ev_frame <= 1'b1;
            end
          end
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  reset_ind_pulse_a: assert property ($rose(pins_s.remote_reset) |=> RESET_IND ##1 !RESET_IND)
    else $error("Remote reset did not give a one-cycle indication.");
  no_carrier_dark_a: assert property (!pins_s.carrier |=> !LINK_INDICATOR && !ACTIVITY_INDICATOR)
    else $error("Indicators lit without carrier.");
  dual_link_on_a: assert property (ctrl.dual && ctrl.ind_en && pins_s.carrier
    && $stable(ctrl) |=> LINK_INDICATOR)
    else $error("Link indicator off with carrier.");
  act_idle_off_a: assert property (!(pins_s.tx_traffic || pins_s.rx_traffic)
    |=> !ACTIVITY_INDICATOR)
    else $error("Activity indicator on without traffic.");
  single_link_steady_a: assert property (!ctrl.dual && ctrl.ind_en && pins_s.carrier
    && !pins_s.rx_traffic && $stable(ctrl) |=> LINK_INDICATOR && !ACTIVITY_INDICATOR)
    else $error("Single indicator not steady with idle carrier.");
  aneg_restart_a: assert property (wr_go && AVS_ADDRESS == `DRP_OFF_CTRL
    && AVS_BYTEENABLE[0]
    && AVS_WRITEDATA[`DRP_CTRL_ANEG_RESTART] |=> AUTONEG_RESTART ##1 !AUTONEG_RESTART)
    else $error("Autonegotiation restart not pulsed.");
  pair_select_a: assert property ((PAIR_ONE_EN != PAIR_TWO_EN) && (ctrl.xover == PAIR_TWO_EN))
    else $error("Pair drive selection wrong.");
  tx_start_bit_a: assert property (tx_state == SER_IDLE && tx_go |=> !SERIAL_TX [*2])
    else $error("Start bit not sent.");
  tx_frame_high_a: assert property (tx_state inside {SER_IDLE, SER_STOP}
    && $stable(tx_state)
    |-> SERIAL_TX)
    else $error("Line not high in idle or stop bit.");
  rx_frame_err_a: assert property (rx_state == SER_STOP && rx_cnt == baud_div - 16'h1
    && !pins_s.serial_rx |=> ev_frame && !ev_rx)
    else $error("Missing framing error.");
  baud_reset_a: assert property ($past(!RST_N) |-> baud_div == `DRP_BAUD_DIV_RST)
    else $error("Baud divisor reset value wrong.");
  blink_reset_a: assert property ($past(!RST_N) |-> blink_cnt == '0 && !blink_phase)
    else $error("Blink counter not cleared by reset.");

  reset_seen_c: cover property (RESET_IND);
  act_blink_c: cover property ($rose(ACTIVITY_INDICATOR));
  rx_byte_c: cover property (ev_rx);
  tx_byte_c: cover property (ev_tx);

endmodule

// file: drp_host_model.sv
// Behavioural model of the automation device port on the serial and reset lines.
`timescale 1ns/100ps
module drp_host_model
(
  input wire logic CLK,
  input wire logic SERIAL_TX,
  output logic SERIAL_RX,
  output logic REMOTE_RESET
);
  // ----
  // Line drivers
  // ----
  // Both lines rest at their idle level from time zero.
  initial
  begin
    SERIAL_RX = 1'b1;
    REMOTE_RESET = 1'b0;
  end

  // The host drives the reset line to the level the bench asks for.
  task automatic set_reset(input logic v);
    REMOTE_RESET <= v;
  endtask

  // A bad stop bit is sent only when the bench asks for it.
  task automatic send(input logic [7:0] b, input int div, input logic stop);
    logic [9:0] frame;
    frame = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      SERIAL_RX <= frame[i];
      repeat (div) @(posedge CLK);
    end
    SERIAL_RX <= 1'b1;
  endtask

  // Samples each bit at its middle, so a late start edge costs no margin.
  task automatic recv(input int div, output logic [7:0] b, output logic stop,
                      output logic ok);
    int n;
    ok = 1'b0;
    b = 8'h00;
    stop = 1'b0;
    for (n = 0; n < 64 && !ok; n++)
    begin
      @(posedge CLK);
      ok = (SERIAL_TX === 1'b0);
    end
    if (ok)
    begin
      repeat (div / 2) @(posedge CLK);
      for (int i = 0; i < 8; i++)
      begin
        repeat (div) @(posedge CLK);
        b[i] = SERIAL_TX;
      end
      repeat (div) @(posedge CLK);
      stop = SERIAL_TX;
    end
  endtask
endmodule

// file: tb.sv
// Self-checking testbench of the drive port block with its host-side model.
`timescale 1ns/100ps
`include "drp_consts.svh"
module tb import drp_pkg::*;;
  // ----
  // Signals
  // ----
  localparam int DIV = 16;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [4:0] AVS_ADDRESS = 5'h00;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic CARRIER_DETECT = 1'b0;
  logic TX_TRAFFIC = 1'b0;
  logic RX_TRAFFIC = 1'b0;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST, IRQ, SERIAL_RX, SERIAL_TX, RESET_IND, REMOTE_RESET;
  logic LINK_INDICATOR, ACTIVITY_INDICATOR, PAIR_ONE_EN, PAIR_TWO_EN;
  logic AUTONEG_EN, AUTONEG_RESTART;
  int error_cnt = 0;
  int check_count = 0;
  int unsigned seed = 95234;

  always #5 CLK = ~CLK;

  // A short blink period keeps the indicator checks within a few cycles.
  drp_top #(.BLINK_CYCLES(8)) dut (.CLK(CLK), .RST_N(RST_N),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ),
    .REMOTE_RESET(REMOTE_RESET), .CARRIER_DETECT(CARRIER_DETECT),
    .TX_TRAFFIC(TX_TRAFFIC), .RX_TRAFFIC(RX_TRAFFIC), .LINK_SPEED(2'h2),
    .SERIAL_RX(SERIAL_RX), .SERIAL_TX(SERIAL_TX), .RESET_IND(RESET_IND),
    .LINK_INDICATOR(LINK_INDICATOR), .ACTIVITY_INDICATOR(ACTIVITY_INDICATOR),
    .PAIR_ONE_EN(PAIR_ONE_EN), .PAIR_TWO_EN(PAIR_TWO_EN),
    .AUTONEG_EN(AUTONEG_EN), .AUTONEG_RESTART(AUTONEG_RESTART));

  drp_host_model host (.CLK(CLK), .SERIAL_TX(SERIAL_TX), .SERIAL_RX(SERIAL_RX),
    .REMOTE_RESET(REMOTE_RESET));

  // ----
  // Helpers
  // ----
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic results();
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Holds the request until waitrequest is seen low, then lets an edge pass.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    AVS_ADDRESS <= a;
    AVS_WRITE <= wr;
    AVS_READ <= ~wr;
    AVS_WRITEDATA <= d;
    for (n = 0; n < 20; n++)
    begin
      @(posedge CLK);
      if (AVS_WAITREQUEST === 1'b0)
        break;
    end
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    if (n == 20)
    begin
      error_cnt++;
      results();
    end
    @(posedge CLK);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask

  function automatic logic pin(input int k);
    case (k)
      0: return RESET_IND;
      1: return AUTONEG_RESTART;
      2: return LINK_INDICATOR;
      3: return ACTIVITY_INDICATOR;
      default: return ~SERIAL_TX;
    endcase
  endfunction

  task automatic watch(input int k, input int n, output int hi, output int tg);
    logic prev;
    prev = pin(k);
    hi = 0;
    tg = 0;
    repeat (n)
    begin
      @(posedge CLK);
      hi += (pin(k) === 1'b1) ? 1 : (pin(k) === 1'b0) ? 0 : 1000;
      tg += (pin(k) !== prev);
      prev = pin(k);
    end
  endtask

  // Codes: 0 off, 1 steady on, 2 blinking, 3 anything else.
  function automatic int code(input int hi, input int tg);
    return (hi > 48) ? 3 : (tg >= 2) ? 2 : (hi == 48 && tg == 0) ? 1 : (hi == 0) ? 0 : 3;
  endfunction

  task automatic ind(input logic c, input logic t, input logic r, input int el,
                     input int ea);
    int hi, tg;
    CARRIER_DETECT <= c;
    TX_TRAFFIC <= t;
    RX_TRAFFIC <= r;
    repeat (8) @(posedge CLK);
    watch(2, 48, hi, tg);
    check(code(hi, tg), el);
    watch(3, 48, hi, tg);
    check(code(hi, tg), ea);
  endtask

  // ----
  // Main sequence
  // ----
  initial
  begin
    logic [31:0] q;
    logic [7:0] b, got;
    logic stop, ok;
    int hi, tg;
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    rd_chk(`DRP_OFF_CTRL, `DRP_CTRL_RST);
    rd_chk(`DRP_OFF_IRQ_MASK, 32'h0);
    rd_chk(`DRP_OFF_BAUD_DIV, `DRP_BAUD_DIV_RST);
    rd_chk(`DRP_OFF_TX_DATA, 32'h0);
    wr(5'h1C, xs());
    rd_chk(5'h1C, 32'h0);
    check({PAIR_ONE_EN, PAIR_TWO_EN, AUTONEG_EN, IRQ}, 4'hA);
    wr(`DRP_OFF_CTRL, 32'h0000000B);
    repeat (2) @(posedge CLK);
    check({PAIR_ONE_EN, PAIR_TWO_EN, AUTONEG_EN}, 3'h2);
    fork
      wr(`DRP_OFF_CTRL, 32'h0000001D);
      watch(1, 10, hi, tg);
    join
    check(hi, 1);
    wr(`DRP_OFF_BAUD_DIV, DIV);
    // Serial out, with a second write while busy that must be dropped.
    repeat (3)
    begin
      b = 8'(xs());
      fork
        begin
          wr(`DRP_OFF_TX_DATA, 32'(b));
          wr(`DRP_OFF_TX_DATA, 32'(~b));
        end
        host.recv(DIV, got, stop, ok);
      join
      check({ok, stop, got}, {2'h3, b});
      watch(4, 3 * DIV, hi, tg);
      check(hi, 0);
      rd(`DRP_OFF_IRQ_STATUS, q);
      check(q[`DRP_IRQ_TX], 1'b1);
    end
    // Serial in: one frame with a bad stop bit, then good frames.
    host.send(8'(xs()), DIV, 1'b0);
    repeat (12 * DIV) @(posedge CLK);
    rd(`DRP_OFF_IRQ_STATUS, q);
    check(q[`DRP_IRQ_FRAME], 1'b1);
    repeat (3)
    begin
      b = 8'(xs());
      host.send(b, DIV, 1'b1);
      repeat (4) @(posedge CLK);
      rd(`DRP_OFF_STATUS, q);
      check(q[3], 1'b1);
      check(q[6:5], 2'h2);
      rd_chk(`DRP_OFF_RX_DATA, b);
      rd(`DRP_OFF_STATUS, q);
      check(q[3], 1'b0);
      rd(`DRP_OFF_IRQ_STATUS, q);
      check(q[`DRP_IRQ_RX], 1'b1);
    end
    // Remote reset, first masked and then unmasked.
    for (int m = 0; m < 2; m++)
    begin
      wr(`DRP_OFF_IRQ_MASK, m);
      host.set_reset(1'b1);
      watch(0, 20, hi, tg);
      check(hi, 1);
      check(IRQ, m);
      host.set_reset(1'b0);
      repeat (8) @(posedge CLK);
      rd(`DRP_OFF_IRQ_STATUS, q);
      check(q[`DRP_IRQ_RESET], 1'b1);
      repeat (2) @(posedge CLK);
      check(IRQ, 1'b0);
      rd(`DRP_OFF_IRQ_STATUS, q);
      check(q[`DRP_IRQ_RESET], 1'b0);
    end
    // Indicators in dual mode, then with the link indicator alone.
    wr(`DRP_OFF_CTRL, 32'h0000000D);
    ind(1'b0, 1'b0, 1'b0, 0, 0);
    ind(1'b1, 1'b0, 1'b0, 1, 0);
    rd(`DRP_OFF_IRQ_STATUS, q);
    check(q[`DRP_IRQ_CARRIER], 1'b1);
    ind(1'b1, 1'b1, 1'b0, 1, 2);
    ind(1'b1, 1'b0, 1'b1, 1, 2);
    ind(1'b0, 1'b1, 1'b1, 0, 0);
    wr(`DRP_OFF_CTRL, 32'h0000000C);
    ind(1'b1, 1'b0, 1'b0, 1, 0);
    ind(1'b1, 1'b1, 1'b0, 1, 0);
    ind(1'b1, 1'b0, 1'b1, 2, 0);
    ind(1'b0, 1'b0, 1'b1, 0, 0);
    // With the indicator enable cleared, both outputs stay dark even with traffic.
    wr(`DRP_OFF_CTRL, 32'h00000005);
    ind(1'b1, 1'b1, 1'b1, 0, 0);
    results();
  end
endmodule
